// *** shared/uotg_params.svh ***
// offsets, field positions, reset values and fixed figures of the register group
`ifndef UOTG_PARAMS_SVH
`define UOTG_PARAMS_SVH
// ************************************************************
// register byte offsets
// ************************************************************
`define UOTG_DEVICE_CONTROL_OFS 12'h000
`define UOTG_HWVER_OFS 12'h004
`define UOTG_IRQ_STAT_OFS 12'h008
`define UOTG_IRQ_MASK_OFS 12'h00c
`define UOTG_EP_PAGE 4'h1
// word index of each register inside one endpoint-direction slot
`define UOTG_EP_SIZE 3'd0
`define UOTG_EP_START 3'd1
`define UOTG_EP_FUNC 3'd2
`define UOTG_EP_HUB 3'd3
`define UOTG_EP_PORT 3'd4
// ************************************************************
// field positions and figures
// ************************************************************
`define UOTG_ROLE_BIT 7
`define UOTG_HNP_BIT 1
`define UOTG_SESS_BIT 0
`define UOTG_DPB_BIT 4
`define UOTG_MULT_BIT 7
`define UOTG_SZ_BASE_EXP 5'd3
`define UOTG_START_UNIT_LOG2 3
`define UOTG_EP0_BYTES 20'h00040
`define UOTG_EP0_START 16'h0000
`define UOTG_NUM_EV 4
`define UOTG_RST_BYTE 8'h00
`endif

// *** shared/uotg_pkg.sv ***
// shared types of the dual-role controller register group
package uotg_pkg;
   // one direction of one endpoint: fifo placement and target addressing
   typedef struct packed {
      logic double_buffer_enable;
      logic [3:0] fifo_size_code;
      logic [12:0] start;
      logic [6:0] target_function_address;
      logic multi_translator_flag;
      logic [6:0] target_hub_address;
      logic [6:0] target_hub_port_number;
   } uotg_ep_cfg_type;
   // fifo geometry in bytes, as the packet buffer logic uses it
   typedef struct packed {
      logic [19:0] bytes;
      logic [15:0] start;
   } uotg_fifo_geom_type;
endpackage

// *** design/uotg_ep_regs.sv ***
// fifo size, fifo start and target address registers of one endpoint direction
`timescale 1ns/1ps
`default_nettype none
`include "uotg_params.svh"
module uotg_ep_regs (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic wr_en, // write strobe for this slot
   input wire logic [2:0] sel, // word index in the slot
   input wire logic [15:0] wdata, // write data
   output logic [15:0] rdata, // read data of sel
   output logic hit, // sel is a mapped register
   output uotg_pkg::uotg_ep_cfg_type cfg, // stored settings
   output uotg_pkg::uotg_fifo_geom_type geom // derived byte geometry
);
   import uotg_pkg::*;
   uotg_ep_cfg_type cfg_ff;
   uotg_ep_cfg_type nxt_cfg;
   wire [4:0] exp_w;
   // each register takes only its own field bits; reserved bits are dropped
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr_en) begin
         case (sel)
            `UOTG_EP_SIZE: begin
               nxt_cfg.double_buffer_enable = wdata[`UOTG_DPB_BIT];
               nxt_cfg.fifo_size_code = wdata[3:0];
            end
            `UOTG_EP_START: nxt_cfg.start = wdata[12:0];
            `UOTG_EP_FUNC: nxt_cfg.target_function_address = wdata[6:0];
            `UOTG_EP_HUB: begin
               nxt_cfg.multi_translator_flag = wdata[`UOTG_MULT_BIT];
               nxt_cfg.target_hub_address = wdata[6:0];
            end
            `UOTG_EP_PORT: nxt_cfg.target_hub_port_number = wdata[6:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= '0;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end
   // read view and derived geometry; double buffering doubles the block
   assign hit = (sel <= `UOTG_EP_PORT);
   assign rdata = (sel == `UOTG_EP_SIZE) ?
                  {11'h000, cfg_ff.double_buffer_enable, cfg_ff.fifo_size_code} :
                  (sel == `UOTG_EP_START) ? {3'h0, cfg_ff.start} :
                  (sel == `UOTG_EP_FUNC) ? {9'h000, cfg_ff.target_function_address} :
                  (sel == `UOTG_EP_HUB) ?
                  {8'h00, cfg_ff.multi_translator_flag, cfg_ff.target_hub_address} :
                  (sel == `UOTG_EP_PORT) ? {9'h000, cfg_ff.target_hub_port_number} :
                  16'h0000;
   assign exp_w = {1'b0, cfg_ff.fifo_size_code} + `UOTG_SZ_BASE_EXP
                  + {4'h0, cfg_ff.double_buffer_enable};
   assign geom.bytes = 20'h00001 << exp_w;
   assign geom.start = {cfg_ff.start, 3'b000};
   assign cfg = cfg_ff;
   chk_size_from_code: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && sel == `UOTG_EP_SIZE |=> geom.bytes ==
      (20'h00001 << ($past(wdata[4]) ? $past(wdata[3:0]) + 5'd4 : $past(wdata[3:0]) + 5'd3)))
      else $error("fifo byte size does not follow the written size code");
   chk_start_eight_units: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && sel == `UOTG_EP_START |=> geom.start == 16'($past(wdata[12:0]) * 8))
      else $error("fifo start is not eight times the written field");
   chk_hub_mult_kept: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && sel == `UOTG_EP_HUB |=> cfg.multi_translator_flag == $past(wdata[7])
      && cfg.target_hub_address == $past(wdata[6:0]))
      else $error("translator flag not stored from bit seven");
endmodule
`default_nettype wire

// *** design/uotg_irq.sv ***
// sticky event status, mask and pending level
`timescale 1ns/1ps
`default_nettype none
module uotg_irq #(
   parameter int NUM_EV = 4 // number of event lines
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic [NUM_EV-1:0] ev, // one-cycle event pulses
   input wire logic stat_wr, // write-one-to-clear strobe
   input wire logic mask_wr, // mask write strobe
   input wire logic [NUM_EV-1:0] wdata, // write data
   output logic [NUM_EV-1:0] stat, // sticky status
   output logic [NUM_EV-1:0] mask, // enable mask
   output logic pend // an unmasked bit is set
);
   logic [NUM_EV-1:0] stat_ff;
   logic [NUM_EV-1:0] mask_ff;
   wire [NUM_EV-1:0] nxt_stat;
   wire [NUM_EV-1:0] nxt_mask;
   initial begin
      if (NUM_EV < 1 || NUM_EV > 32) $error("event count out of range");
   end
   // a new event wins over a clear written in the same cycle
   assign nxt_stat = ev | (stat_ff & ~(stat_wr ? wdata : '0));
   assign nxt_mask = mask_wr ? wdata : mask_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_ff <= '0;
         mask_ff <= '0;
      end else begin
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
      end
   end
   assign stat = stat_ff;
   assign mask = mask_ff;
   assign pend = |(stat_ff & mask_ff);
   chk_event_sticks: assert property (@(posedge pclk) disable iff (!presetn)
      ev[0] |=> stat[0] ##1 (stat[0] || $past(stat_wr && wdata[0])))
      else $error("event bit lost or cleared without a write");
endmodule
`default_nettype wire

// *** design/uotg_regs.sv ***
// device control, fifo sizing, version and host target registers on apb
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uotg_params.svh"
module uotg_regs #(
   parameter int NUM_EP = 4, // dynamically sized endpoints
   parameter logic REL_CAND = 1'b0, // arbitrary value
   parameter logic [4:0] VER_MAJOR = 5'h01, // arbitrary value
   parameter logic [9:0] VER_MINOR = 10'h000 // arbitrary value
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic a_or_b_role, // 0 a side, 1 b side
   input wire logic fast_peer_seen, // full or high speed peer
   input wire logic slow_peer_seen, // low speed peer
   input wire logic [1:0] vbus_level, // supply band
   input wire logic acting_host_flag, // controller is host
   input wire logic suspended, // bus is in suspend
   input wire logic hnp_done, // negotiation finished, pulse
   input wire logic sess_began, // b side session start, pulse
   input wire logic sess_ended, // b side session end, pulse
   output logic session, // session bit
   output logic hnp_start, // negotiation may run, level
   output logic srp_start, // session request, pulse
   output logic soft_disconnect, // software disconnect, pulse
   output logic irq, // interrupt, level
   output uotg_pkg::uotg_fifo_geom_type [2*NUM_EP:0] fifo_geom, // 0 is endpoint 0
   output uotg_pkg::uotg_ep_cfg_type [2*NUM_EP-1:0] ep_cfg // (ep-1)*2+rx
);
   import uotg_pkg::*;
   localparam int NEPS = 2 * NUM_EP;
   localparam int NUM_EV = `UOTG_NUM_EV;

   initial begin
      if (NUM_EP < 1 || NUM_EP > 4) $error("endpoint count must be 1 to 4");
      if (VER_MINOR > 10'd999) $error("minor version above 999");
   end

   // ************************************************************
   // apb decode
   // ************************************************************
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   wire acc;
   wire wr_acc;
   wire rd_acc;
   wire is_dev;
   wire is_ver;
   wire is_stat;
   wire is_mask;
   wire is_ep;
   wire mapped;
   wire [2:0] ep_idx;
   wire [2:0] ep_sel;
   wire [31:0] rd_word;

   // one wait state: the answer is registered, so pready rises one edge
   // after the access phase opens and drops again right after
   assign acc = psel & penable & ~pready_ff;
   assign wr_acc = acc & pwrite;
   assign rd_acc = acc & ~pwrite;
   assign ep_idx = paddr[7:5];
   assign ep_sel = paddr[4:2];
   assign is_dev = (paddr == `UOTG_DEVICE_CONTROL_OFS);
   assign is_ver = (paddr == `UOTG_HWVER_OFS);
   assign is_stat = (paddr == `UOTG_IRQ_STAT_OFS);
   assign is_mask = (paddr == `UOTG_IRQ_MASK_OFS);

   // ************************************************************
   // endpoint slots, transmit and receive kept apart
   // ************************************************************
   logic [15:0] ep_rdata [0:7];
   logic [7:0] ep_hit;
   uotg_fifo_geom_type geom_ff [0:NEPS];
   uotg_fifo_geom_type ep_geom [0:7];

   assign is_ep = (paddr[11:8] == `UOTG_EP_PAGE) && (paddr[1:0] == 2'b00)
                  && (32'(ep_idx) < NEPS) && ep_hit[ep_idx];

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_ep
         if (gi < NEPS) begin : g_on
            wire slot_wr;
            // every slot has its own storage, so no direction shadows another
            assign slot_wr = wr_acc && is_ep && (ep_idx == 3'(gi));
            uotg_ep_regs u_ep (
               .pclk(pclk),
               .presetn(presetn),
               .wr_en(slot_wr),
               .sel(ep_sel),
               .wdata(pwdata[15:0]),
               .rdata(ep_rdata[gi]),
               .hit(ep_hit[gi]),
               .cfg(ep_cfg[gi]),
               .geom(ep_geom[gi])
            );
            // geometry is retimed so the buffer logic sees flop outputs
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  geom_ff[gi+1] <= '0;
               end else begin
                  geom_ff[gi+1] <= ep_geom[gi];
               end
            end
            assign fifo_geom[gi+1] = geom_ff[gi+1];
         end else begin : g_off
            assign ep_rdata[gi] = 16'h0000;
            assign ep_hit[gi] = 1'b0;
            assign ep_geom[gi] = '0;
         end
      end
   endgenerate

   // endpoint 0 is not programmable: 64 bytes at the bottom of the ram
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         geom_ff[0] <= {`UOTG_EP0_BYTES, `UOTG_EP0_START};
      end else begin
         geom_ff[0] <= {`UOTG_EP0_BYTES, `UOTG_EP0_START};
      end
   end
   assign fifo_geom[0] = geom_ff[0];

   // ************************************************************
   // device control
   // ************************************************************
   logic session_ff;
   logic hnp_req_ff;
   logic hnp_start_ff;
   logic srp_ff;
   logic sdis_ff;
   wire dev_wr;
   wire nxt_session;
   wire nxt_hnp_req;
   wire nxt_hnp_start;
   wire nxt_srp;
   wire nxt_sdis;
   wire [7:0] device_control_view;

   assign dev_wr = wr_acc & is_dev;

   // read view; peer speed flags only mean something in host mode, so
   // they are masked outside it rather than showing stale line states
   assign device_control_view = {a_or_b_role,
                         fast_peer_seen & acting_host_flag,
                         slow_peer_seen & acting_host_flag,
                         vbus_level,
                         acting_host_flag,
                         hnp_req_ff,
                         session_ff};

   // on the b side the controller's own session events beat a write
   assign nxt_session = (a_or_b_role & sess_began) ? 1'b1 :
                        (a_or_b_role & sess_ended) ? 1'b0 :
                        dev_wr ? pwdata[`UOTG_SESS_BIT] : session_ff;

   // a request written on the b side wins over a completion the same cycle
   assign nxt_hnp_req = (dev_wr & a_or_b_role) ? pwdata[`UOTG_HNP_BIT] :
                        hnp_done ? 1'b0 : hnp_req_ff;
   assign nxt_hnp_start = hnp_req_ff & a_or_b_role & suspended & ~hnp_done;

   // session request on a rising write; disconnect on a clear in suspend
   assign nxt_srp = dev_wr & pwdata[`UOTG_SESS_BIT] & ~session_ff;
   assign nxt_sdis = dev_wr & ~pwdata[`UOTG_SESS_BIT] & session_ff & suspended;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         session_ff <= 1'b0;
         hnp_req_ff <= 1'b0;
         hnp_start_ff <= 1'b0;
         srp_ff <= 1'b0;
         sdis_ff <= 1'b0;
      end else begin
         session_ff <= nxt_session;
         hnp_req_ff <= nxt_hnp_req;
         hnp_start_ff <= nxt_hnp_start;
         srp_ff <= nxt_srp;
         sdis_ff <= nxt_sdis;
      end
   end

   assign session = session_ff;
   assign hnp_start = hnp_start_ff;
   assign srp_start = srp_ff;
   assign soft_disconnect = sdis_ff;

   // ************************************************************
   // events and interrupt
   // ************************************************************
   logic irq_ff;
   wire [NUM_EV-1:0] ev;
   wire [NUM_EV-1:0] irq_stat;
   wire [NUM_EV-1:0] irq_mask;
   wire irq_pend;

   // bit 0 session up, 1 session down, 2 negotiation done, 3 disconnect
   assign ev = {nxt_sdis,
                hnp_done & hnp_req_ff,
                session_ff & ~nxt_session,
                nxt_session & ~session_ff};

   uotg_irq #(
      .NUM_EV(NUM_EV)
   ) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .ev(ev),
      .stat_wr(wr_acc & is_stat),
      .mask_wr(wr_acc & is_mask),
      .wdata(pwdata[NUM_EV-1:0]),
      .stat(irq_stat),
      .mask(irq_mask),
      .pend(irq_pend)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= irq_pend;
      end
   end
   assign irq = irq_ff;

   // ************************************************************
   // read mux and apb answer
   // ************************************************************
   assign mapped = is_dev | is_ver | is_stat | is_mask | is_ep;
   assign rd_word = is_dev ? {24'h000000, device_control_view} :
                    is_ver ? {16'h0000, REL_CAND, VER_MAJOR, VER_MINOR} :
                    is_stat ? 32'(irq_stat) :
                    is_mask ? 32'(irq_mask) :
                    is_ep ? {16'h0000, ep_rdata[ep_idx]} :
                    32'h00000000;

   // data and error are held for the single cycle pready is high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= acc;
         pslverr_ff <= acc & ~mapped;
         prdata_ff <= rd_acc ? rd_word : 32'h00000000;
      end
   end

   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata = prdata_ff;

   // ************************************************************
   // checks
   // ************************************************************
   chk_role_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && is_dev |=> pready && prdata[`UOTG_ROLE_BIT] == $past(a_or_b_role))
      else $error("role bit does not show the role input");

   chk_fast_host_only: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && is_dev |=> prdata[6] == $past(fast_peer_seen && acting_host_flag))
      else $error("fast peer flag wrong");

   chk_slow_host_only: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && is_dev |=> prdata[5] == $past(slow_peer_seen && acting_host_flag))
      else $error("slow peer flag wrong");

   chk_vbus_band: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && is_dev |=> prdata[4:3] == $past(vbus_level) && prdata[2] ==
      $past(acting_host_flag))
      else $error("supply band or host flag wrong");

   chk_hnp_cleared: assert property (@(posedge pclk) disable iff (!presetn)
      hnp_done && !dev_wr |=> !hnp_req_ff ##1 !hnp_start)
      else $error("host request survives negotiation end");

   chk_b_session_follows: assert property (@(posedge pclk) disable iff (!presetn)
      a_or_b_role && sess_ended && !sess_began |=> !session)
      else $error("b side session did not end");

   chk_soft_disc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      dev_wr && !pwdata[0] && session_ff && suspended |=> soft_disconnect ##1 !soft_disconnect)
      else $error("software disconnect not a single pulse");

   chk_ep0_fixed: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_geom[0].bytes == 20'h00040 && fifo_geom[0].start == 16'h0000)
      else $error("endpoint 0 fifo moved");

   chk_version_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc && is_ver |=> prdata[15:0] == {REL_CAND, VER_MAJOR, VER_MINOR}
      && prdata[31:16] == 16'h0000)
      else $error("version word wrong");

   chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle after access");
endmodule
`default_nettype wire

// *** tb/uotg_peer_model.sv ***
// peer across the cable: role, speed, supply band and session events
`timescale 1ns/1ps
`default_nettype none
module uotg_peer_model (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic [9:0] want, // b,host,fast,slow,lvl[2],susp,up,down,neg
   output logic a_or_b_role, // 0 a side, 1 b side
   output logic fast_peer_seen, // fast peer attached
   output logic slow_peer_seen, // slow peer attached
   output logic [1:0] vbus_level, // supply band
   output logic acting_host_flag, // controller is host
   output logic suspended, // bus in suspend
   output logic hnp_done, // negotiation finished, pulse
   output logic sess_began, // b side session start, pulse
   output logic sess_ended // b side session end, pulse
);
   // *****
   // peer state
   // *****
   // events are only raised where a real peer could raise them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {a_or_b_role, fast_peer_seen, slow_peer_seen, vbus_level} <= '0;
         {acting_host_flag, suspended, hnp_done, sess_began, sess_ended} <= '0;
      end else begin
         a_or_b_role <= want[0];
         fast_peer_seen <= want[1] & want[2];
         slow_peer_seen <= want[1] & want[3];
         vbus_level <= want[5:4];
         acting_host_flag <= want[1];
         suspended <= want[6];
         hnp_done <= want[9] & want[6] & want[0];
         sess_began <= want[7] & want[0];
         sess_ended <= want[8] & want[0];
      end
   end
endmodule
`default_nettype wire

// *** tb/uotg_regs_test.sv ***
// self-checking bench of the register group
`timescale 1ns/1ps
`default_nettype none
`include "uotg_params.svh"
module uotg_regs_test;
   import uotg_pkg::*;
   // *****
   // harness
   // *****
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, role, fast, slow, host, susp, hdone, sup, sdown;
   logic session, hnp_start, srp_start, soft_disconnect, irq;
   logic [1:0] lvl;
   logic [9:0] want = 10'h000;
   uotg_fifo_geom_type [8:0] geom;
   uotg_ep_cfg_type [7:0] cfg;
   int err_count = 0, samples_checked = 0, srp_n = 0, sd_n = 0;
   uotg_regs #(.REL_CAND(1'h1), .VER_MAJOR(5'h1f), .VER_MINOR(10'h3e7)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .a_or_b_role(role), .fast_peer_seen(fast), .slow_peer_seen(slow), .vbus_level(lvl),
      .acting_host_flag(host), .suspended(susp), .hnp_done(hdone), .sess_began(sup),
      .sess_ended(sdown), .session(session), .hnp_start(hnp_start), .srp_start(srp_start),
      .soft_disconnect(soft_disconnect), .irq(irq), .fifo_geom(geom), .ep_cfg(cfg));
   uotg_peer_model i_peer (.pclk(pclk), .presetn(presetn), .want(want), .a_or_b_role(role),
      .fast_peer_seen(fast), .slow_peer_seen(slow), .vbus_level(lvl),
      .acting_host_flag(host), .suspended(susp), .hnp_done(hdone), .sess_began(sup),
      .sess_ended(sdown));
   always #12.5 pclk = ~pclk;
   // pulses stand one cycle, so they are counted at every edge
   always @(posedge pclk) begin
      if (srp_start === 1'h1) srp_n++;
      if (soft_disconnect === 1'h1) sd_n++;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // holds the request until pready is seen high, then releases it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // no cycle count is assumed here: only the watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task peer(input logic [9:0] w);
      want <= w;
      repeat (4) @(posedge pclk);
   endtask
   task pulse(input int i);
      want[i] <= 1'h1;
      @(posedge pclk);
      want[i] <= 1'h0;
      repeat (4) @(posedge pclk);
   endtask
   task st(input logic [9:0] w, input logic [31:0] exp);
      peer(w);
      apb(1'h0, `UOTG_DEVICE_CONTROL_OFS, 32'h0);
      chk(rd, exp);
   endtask
   // *****
   // scenarios
   // *****
   task t_reset;
      chk(32'(geom[0].bytes), 32'h40);
      chk(32'(geom[0].start), 32'h0);
      apb(1'h1, `UOTG_HWVER_OFS, 32'h0);
      apb(1'h0, `UOTG_HWVER_OFS, 32'h0);
      chk(rd, 32'hffe7);
      apb(1'h0, 12'h010, 32'h0);
      chk(32'(err), 32'h1);
   endtask
   task t_fifo;
      // regions kept apart: slot 7 sits just above endpoint 0, slot 0 at the top
      apb(1'h1, 12'h100, 32'hff);
      apb(1'h1, 12'h104, 32'hffff);
      apb(1'h1, 12'h1e0, 32'h03);
      apb(1'h1, 12'h1e4, 32'h08);
      apb(1'h0, 12'h100, 32'h0);
      chk(rd, 32'h1f);
      apb(1'h0, 12'h104, 32'h0);
      chk(rd, 32'h1fff);
      chk(32'(geom[1].bytes), 32'h80000);
      chk(32'(geom[1].start), 32'hfff8);
      chk(32'(geom[8].bytes), 32'h40);
      chk(32'(geom[8].start), 32'h40);
      chk(32'(geom[2].bytes), 32'h8);
   endtask
   task t_target;
      apb(1'h1, 12'h128, 32'hff);
      apb(1'h1, 12'h12c, 32'hff);
      apb(1'h1, 12'h130, 32'hff);
      apb(1'h0, 12'h128, 32'h0);
      chk(rd, 32'h7f);
      apb(1'h0, 12'h12c, 32'h0);
      chk(rd, 32'hff);
      apb(1'h0, 12'h130, 32'h0);
      chk(rd, 32'h7f);
      chk(32'(cfg[1].target_hub_port_number), 32'h7f);
      apb(1'h0, 12'h108, 32'h0);
      chk(rd, 32'h0);
   endtask
   task t_session;
      peer(10'h000);
      apb(1'h1, `UOTG_DEVICE_CONTROL_OFS, 32'h1);
      chk(32'(srp_n), 32'h1);
      apb(1'h1, `UOTG_DEVICE_CONTROL_OFS, 32'h3);
      st(10'h040, 32'h1);
      apb(1'h1, `UOTG_DEVICE_CONTROL_OFS, 32'h0);
      chk(32'(sd_n), 32'h1);
      apb(1'h1, `UOTG_IRQ_MASK_OFS, 32'hf);
      st(10'h041, 32'h80);
      apb(1'h1, `UOTG_DEVICE_CONTROL_OFS, 32'h2);
      st(10'h041, 32'h82);
      chk(32'(hnp_start), 32'h1);
      // clear older events first so the interrupt below is owed to negotiation
      apb(1'h1, `UOTG_IRQ_STAT_OFS, 32'hf);
      chk(32'(irq), 32'h0);
      pulse(9);
      st(10'h041, 32'h80);
      chk(32'(irq), 32'h1);
      apb(1'h0, `UOTG_IRQ_STAT_OFS, 32'h0);
      chk(rd, 32'h4);
      apb(1'h1, `UOTG_IRQ_STAT_OFS, 32'hf);
      chk(32'(irq), 32'h0);
      pulse(7);
      chk(32'(session), 32'h1);
      pulse(8);
      chk(32'(session), 32'h0);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_reset;
      st(10'h027, 32'hd4);
      st(10'h03a, 32'h3c);
      st(10'h025, 32'h90);
      t_fifo;
      t_target;
      t_session;
      summarize;
   end
   initial begin
      #100000;
      err_count++;
      summarize;
   end
endmodule
`default_nettype wire
